// File: fwpfs_params.svh
// constants for the fifo write port, flags and serial offset block
`ifndef FWPFS_PARAMS_SVH
`define FWPFS_PARAMS_SVH

// ==========================================================
// register byte addresses
`define FWPFS_ADDR_STATUS 8'h00
`define FWPFS_ADDR_MASK 8'h04
`define FWPFS_ADDR_MODE 8'h08
`define FWPFS_ADDR_LEVEL 8'h0C
`define FWPFS_ADDR_OFFSETS 8'h10

// ==========================================================
// status and mask bit positions
`define FWPFS_EV_FULL 0
`define FWPFS_EV_ALMOST_FULL 1
`define FWPFS_EV_OVERFLOW 2
`define FWPFS_EV_SERIAL_LOAD 3
`define FWPFS_EV_N 4

// ==========================================================
// mode and offsets register bit positions
`define FWPFS_MODE_ASYNC 0
`define FWPFS_MODE_FALL_THROUGH_MODE 1
`define FWPFS_MODE_WIDTH 2
`define FWPFS_MODE_FSEL 4
`define FWPFS_OFS_AF_POS 16

// ==========================================================
// bus width codes and data widths
`define FWPFS_BW_36 2'b00
`define FWPFS_BW_18 2'b01
`define FWPFS_BW_9 2'b10
`define FWPFS_DATA_W 36
`define FWPFS_MASK_18 36'h00003FFFF
`define FWPFS_MASK_9 36'h0000001FF
`define FWPFS_MASK_36 36'hFFFFFFFFF

// ==========================================================
// preset offsets chosen by the default offset select pins
`define FWPFS_PRESET_0 7
`define FWPFS_PRESET_1 31
`define FWPFS_PRESET_2 63
`define FWPFS_PRESET_3 127

// ==========================================================
// mask reset value, default depth and offset width
`define FWPFS_MASK_RESET 4'h0
`define FWPFS_DEPTH 1024
`define FWPFS_OFS_W 10

`endif

// File: fwpfs_pkg.sv
// types for the fifo write port, flags and serial offset block
`default_nettype none

package fwpfs_pkg;

  // serial readback sequencer states, one-hot
  typedef enum logic [1:0] {
    FWPFS_SR_IDLE = 2'b01,
    FWPFS_SR_SHIFT = 2'b10
  } fwpfs_sr_state_e;

  // bus width selection code
  typedef logic [1:0] fwpfs_width_t;

endpackage

`default_nettype wire

// File: fwpfs_sync.sv
// two flip-flop synchroniser for pins from outside the clock domain
`timescale 1ns/1ns
`default_nettype none

module fwpfs_sync #(
  parameter int W = 1
) (
  // clock
  input wire logic i_sys_clk,
  // asynchronous pins and synchronised copy
  input wire logic [W-1:0] i_d,
  output logic [W-1:0] o_q
);

  logic [W-1:0] meta_reg;
  logic [W-1:0] q_reg;

  // first stage read only by the second
  always_ff @(posedge i_sys_clk) begin
    meta_reg <= i_d;
    q_reg <= meta_reg;
  end

  assign o_q = q_reg;

endmodule

`default_nettype wire

// File: fwpfs_top.sv
// fifo write port, full and almost-full flags, serial offset access
//
// Summary of operation
// [R1] readback enable low copies both offsets
// [R2] readback low shifts one bit per edge
// [R3] serial access only when select is zero
// [R4] async select at reset picks write mode
// [R5] async mode needs standard timing, enable low
// [R6] standard mode output shows memory full
// [R7] fall-through mode output shows input ready
// [R8] almost-full high while free exceeds offset
// [R9] load enable low shifts serial input in
// [R10] sync mode writes on enabled clock edge
// [R11] async mode writes on strobe rising edge
// [R12] chip select gates write data acceptance
// [R13] input width 36, 18 or 9 bits
// [R14] fall-through select at reset picks timing
// [R15] preset select at reset sets both offsets
// [R16] load and readback share order and length
//
// Design decisions made here: the address map and the address-and-strobe port.
`timescale 1ns/1ns
`default_nettype none
`include "fwpfs_params.svh"

module fwpfs_top
  import fwpfs_pkg::*;
#(
  parameter int DEPTH = `FWPFS_DEPTH,
  parameter int OFS_W = `FWPFS_OFS_W
) (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst,
  // write port pins
  input wire logic i_write_clk_strobe,
  input wire logic i_write_enable_n,
  input wire logic i_input_bus_select_n,
  input wire logic [`FWPFS_DATA_W-1:0] i_data,
  // mode pins sampled at reset
  input wire logic i_write_port_async_select,
  input wire logic i_fall_through_mode,
  input wire logic [1:0] i_default_offset_select,
  input wire logic [1:0] i_bus_width_select,
  // serial offset pins
  input wire logic i_shift_clk,
  input wire logic i_serial_load_enable_n,
  input wire logic i_serial_readback_enable_n,
  input wire logic i_scan_or_serial_select,
  input wire logic i_serial_in,
  output logic o_serial_out,
  // flag pins
  output logic o_full_or_ready_output_n,
  output logic o_almost_full_flag_n,
  // stored words toward memory, and words drained from it
  output logic o_word_valid,
  output logic [`FWPFS_DATA_W-1:0] o_word_data,
  input wire logic i_word_drained,
  // register port
  input wire logic [7:0] i_reg_addr,
  input wire logic [31:0] i_reg_wdata,
  input wire logic i_reg_write,
  input wire logic i_reg_read,
  output logic [31:0] o_reg_rdata,
  // interrupt
  output logic o_irq
);

  localparam int CNT_W = $clog2(DEPTH) + 1;
  localparam int SH_W = 2 * OFS_W;
  localparam logic [CNT_W-1:0] DEPTH_C = CNT_W'(DEPTH);

  // ==========================================================
  // pin synchronisers
  logic [13:0] pins_s;
  logic [`FWPFS_DATA_W-1:0] data_s;

  fwpfs_sync #(.W(14)) u_sync_pins (
    .i_sys_clk(i_sys_clk),
    .i_d({i_write_clk_strobe, i_write_enable_n, i_input_bus_select_n,
          i_write_port_async_select, i_fall_through_mode,
          i_default_offset_select, i_bus_width_select, i_shift_clk,
          i_serial_load_enable_n, i_serial_readback_enable_n,
          i_scan_or_serial_select, i_serial_in}),
    .o_q(pins_s)
  );

  fwpfs_sync #(.W(`FWPFS_DATA_W)) u_sync_data (
    .i_sys_clk(i_sys_clk),
    .i_d(i_data),
    .o_q(data_s)
  );

  logic wclk_s, wen_n_s, wcs_n_s, async_s, fall_through_mode_s;
  logic [1:0] fsel_s;
  fwpfs_width_t bw_s;
  logic sclk_s, serial_load_enable_n_s, serial_readback_enable_n_s, scan_or_serial_select_s, si_s;

  assign wclk_s = pins_s[13];
  assign wen_n_s = pins_s[12];
  assign wcs_n_s = pins_s[11];
  assign async_s = pins_s[10];
  assign fall_through_mode_s = pins_s[9];
  assign fsel_s = pins_s[8:7];
  assign bw_s = pins_s[6:5];
  assign sclk_s = pins_s[4];
  assign serial_load_enable_n_s = pins_s[3];
  assign serial_readback_enable_n_s = pins_s[2];
  assign scan_or_serial_select_s = pins_s[1];
  assign si_s = pins_s[0];

  // ==========================================================
  // edge finders on the sampled clocks
  logic wclk_prev_reg, sclk_prev_reg;
  logic wclk_rise, sclk_rise;

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      wclk_prev_reg <= 1'b1;
      sclk_prev_reg <= 1'b1;
    end else begin
      wclk_prev_reg <= wclk_s;
      sclk_prev_reg <= sclk_s;
    end
  end

  assign wclk_rise = wclk_s & ~wclk_prev_reg;
  assign sclk_rise = sclk_s & ~sclk_prev_reg;

  // ==========================================================
  // mode capture while reset is held
  logic async_mode_reg, fall_through_mode_mode_reg;
  fwpfs_width_t width_reg;
  logic [1:0] fsel_reg;

  // [R4] [R14] latch strap pins
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      async_mode_reg <= ~async_s;
      fall_through_mode_mode_reg <= fall_through_mode_s;
      width_reg <= bw_s;
      fsel_reg <= fsel_s;
    end
  end

  // ==========================================================
  // write acceptance
  logic wr_try, wr_accept, full;
  logic [CNT_W-1:0] count_reg;
  logic [`FWPFS_DATA_W-1:0] width_mask;

  assign full = (count_reg == DEPTH_C);

  // [R5] async relies on enable tied low, so it is ignored
  // [R10] [R11] [R12] edge, enable and chip select
  assign wr_try = wclk_rise & ~wcs_n_s & (async_mode_reg | ~wen_n_s);
  assign wr_accept = wr_try & ~full;

  // [R13] active input width
  always_comb begin
    case (width_reg)
      `FWPFS_BW_18: width_mask = `FWPFS_MASK_18;
      `FWPFS_BW_9: width_mask = `FWPFS_MASK_9;
      default: width_mask = `FWPFS_MASK_36;
    endcase
  end

  // stored word handed onward
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_word_valid <= 1'b0;
      o_word_data <= 36'h000000000;
    end else begin
      o_word_valid <= wr_accept;
      if (wr_accept) begin
        o_word_data <= data_s & width_mask;
      end
    end
  end

  // ==========================================================
  // word count
  logic drain;
  assign drain = i_word_drained & (count_reg != '0);

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      count_reg <= '0;
    end else if (wr_accept & ~drain) begin
      count_reg <= count_reg + 1'b1;
    end else if (drain & ~wr_accept) begin
      count_reg <= count_reg - 1'b1;
    end
  end

  // ==========================================================
  // offsets, serial load and readback
  logic [OFS_W-1:0] ae_ofs_reg, af_ofs_reg, preset;
  logic [SH_W-1:0] rb_sh_reg;
  fwpfs_sr_state_e sr_state_reg;
  logic serial_on, load_edge, rb_edge;

  // [R3] serial pins only act with select low
  assign serial_on = ~scan_or_serial_select_s;
  assign load_edge = serial_on & sclk_rise & ~serial_load_enable_n_s;
  assign rb_edge = serial_on & sclk_rise & ~serial_readback_enable_n_s;

  // preset table
  always_comb begin
    case (fsel_s)
      2'b00: preset = OFS_W'(`FWPFS_PRESET_0);
      2'b01: preset = OFS_W'(`FWPFS_PRESET_1);
      2'b10: preset = OFS_W'(`FWPFS_PRESET_2);
      default: preset = OFS_W'(`FWPFS_PRESET_3);
    endcase
  end

  // [R15] preset on reset, then [R9] serial shift in
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      ae_ofs_reg <= preset;
      af_ofs_reg <= preset;
    end else if (load_edge) begin
      // [R16] shared chain, first bit ends at top
      {ae_ofs_reg, af_ofs_reg} <= {ae_ofs_reg[OFS_W-2:0], af_ofs_reg, si_s};
    end
  end

  // [R1] [R2] readback sequencer
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      sr_state_reg <= FWPFS_SR_IDLE;
      rb_sh_reg <= '0;
      o_serial_out <= 1'b0;
    end else if (sclk_rise & (serial_readback_enable_n_s | ~serial_on)) begin
      sr_state_reg <= FWPFS_SR_IDLE;
    end else if (rb_edge) begin
      case (sr_state_reg)
        FWPFS_SR_IDLE: begin
          // [R16] top bit out first, same as load
          rb_sh_reg <= {ae_ofs_reg[OFS_W-2:0], af_ofs_reg, 1'b0};
          o_serial_out <= ae_ofs_reg[OFS_W-1];
          sr_state_reg <= FWPFS_SR_SHIFT;
        end
        FWPFS_SR_SHIFT: begin
          // next bit to send always sits on top
          rb_sh_reg <= {rb_sh_reg[SH_W-2:0], 1'b0};
          o_serial_out <= rb_sh_reg[SH_W-1];
        end
        default: sr_state_reg <= FWPFS_SR_IDLE;
      endcase
    end
  end

  // ==========================================================
  // flags
  logic [CNT_W-1:0] free;
  logic af_clear;
  assign free = DEPTH_C - count_reg;

  // [R8] free space above offset
  assign af_clear = (32'(free) > 32'(af_ofs_reg));

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_full_or_ready_output_n <= 1'b1;
      o_almost_full_flag_n <= 1'b1;
    end else begin
      // [R6] full low, [R7] ready low
      o_full_or_ready_output_n <= fall_through_mode_mode_reg ? full : ~full;
      o_almost_full_flag_n <= af_clear;
    end
  end

  // ==========================================================
  // events and interrupt
  logic [`FWPFS_EV_N-1:0] status_reg, mask_reg, events;
  logic full_prev_reg, afull_prev_reg, status_rd;

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      full_prev_reg <= 1'b0;
      afull_prev_reg <= 1'b0;
    end else begin
      full_prev_reg <= full;
      afull_prev_reg <= ~af_clear;
    end
  end

  always_comb begin
    events = '0;
    events[`FWPFS_EV_FULL] = full & ~full_prev_reg;
    events[`FWPFS_EV_ALMOST_FULL] = ~af_clear & ~afull_prev_reg;
    events[`FWPFS_EV_OVERFLOW] = wr_try & full;
    events[`FWPFS_EV_SERIAL_LOAD] = load_edge;
  end

  assign status_rd = i_reg_read & (i_reg_addr == `FWPFS_ADDR_STATUS);

  // sticky status, read clears, new event wins
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      status_reg <= '0;
    end else begin
      status_reg <= (status_rd ? '0 : status_reg) | events;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      mask_reg <= `FWPFS_MASK_RESET;
    end else if (i_reg_write & (i_reg_addr == `FWPFS_ADDR_MASK)) begin
      mask_reg <= i_reg_wdata[`FWPFS_EV_N-1:0];
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= |(status_reg & mask_reg);
    end
  end

  // ==========================================================
  // register read
  logic [31:0] rd_mux;

  always_comb begin
    rd_mux = 32'h00000000;
    case (i_reg_addr)
      `FWPFS_ADDR_STATUS: rd_mux[`FWPFS_EV_N-1:0] = status_reg;
      `FWPFS_ADDR_MASK: rd_mux[`FWPFS_EV_N-1:0] = mask_reg;
      `FWPFS_ADDR_MODE: begin
        rd_mux[`FWPFS_MODE_ASYNC] = async_mode_reg;
        rd_mux[`FWPFS_MODE_FALL_THROUGH_MODE] = fall_through_mode_mode_reg;
        rd_mux[`FWPFS_MODE_WIDTH +: 2] = width_reg;
        rd_mux[`FWPFS_MODE_FSEL +: 2] = fsel_reg;
      end
      `FWPFS_ADDR_LEVEL: rd_mux[CNT_W-1:0] = count_reg;
      `FWPFS_ADDR_OFFSETS: begin
        rd_mux[OFS_W-1:0] = ae_ofs_reg;
        rd_mux[`FWPFS_OFS_AF_POS +: OFS_W] = af_ofs_reg;
      end
      default: rd_mux = 32'h00000000;
    endcase
  end

  // read data one cycle after the strobe, zero otherwise
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_reg_rdata <= 32'h00000000;
    end else begin
      o_reg_rdata <= i_reg_read ? rd_mux : 32'h00000000;
    end
  end

endmodule

`default_nettype wire

// File: fwpfs_checker.sv
// assertion checker for the fifo write port block
`timescale 1ns/1ns
`default_nettype none
`include "fwpfs_params.svh"
module fwpfs_checker #(
  parameter int DEPTH = 16
) (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst,
  // pins
  input wire logic i_write_clk_strobe,
  input wire logic i_write_enable_n,
  input wire logic i_input_bus_select_n,
  input wire logic i_write_port_async_select,
  input wire logic i_fall_through_mode,
  input wire logic [1:0] i_default_offset_select,
  input wire logic i_scan_or_serial_select,
  input wire logic i_word_drained,
  input wire logic i_reg_read,
  // outputs
  input wire logic o_serial_out,
  input wire logic o_full_or_ready_output_n,
  input wire logic o_almost_full_flag_n,
  input wire logic o_word_valid,
  input wire logic [31:0] o_reg_rdata
);
  logic ft_reg;
  logic sync_reg;
  int af_reg;
  int cnt_reg;
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (i_rst);
  // ==========================================================
  // straps and a word count mirrored from the ports
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      ft_reg <= i_fall_through_mode;
      sync_reg <= i_write_port_async_select;
      case (i_default_offset_select)
        2'h0: af_reg <= `FWPFS_PRESET_0;
        2'h1: af_reg <= `FWPFS_PRESET_1;
        2'h2: af_reg <= `FWPFS_PRESET_2;
        default: af_reg <= `FWPFS_PRESET_3;
      endcase
      cnt_reg <= 0;
    end else if (o_word_valid) begin
      cnt_reg <= cnt_reg + 1;
    end else if (i_word_drained && cnt_reg > 0) begin
      cnt_reg <= cnt_reg - 1;
    end
  end
  // ==========================================================
  // assertions
  a_rdata_idle: assert property (!$past(i_reg_read) |-> o_reg_rdata == 0)
    else $error("read data outside read cycle");
  a_word_pulse: assert property (
    o_word_valid |=> !o_word_valid) else $error("word valid too long");
  a_write_gate: assert property (
    o_word_valid |-> !$past(i_input_bus_select_n, 3))
    else $error("write taken while deselected");
  a_write_enab: assert property (
    o_word_valid && sync_reg |-> !$past(i_write_enable_n, 3))
    else $error("write taken while disabled");
  a_write_edge: assert property (
    o_word_valid |-> $past(i_write_clk_strobe, 3))
    else $error("write without clock rise");
  a_serial_gate: assert property (
    i_scan_or_serial_select && $past(i_scan_or_serial_select, 4)
    |-> $stable(o_serial_out)) else $error("serial out moved");
  a_full_std: assert property (
    !$past(i_rst) && $stable(cnt_reg) && !ft_reg
    |-> o_full_or_ready_output_n == (cnt_reg != DEPTH))
    else $error("full flag wrong");
  a_ready_ft: assert property (
    !$past(i_rst) && $stable(cnt_reg) && ft_reg
    |-> o_full_or_ready_output_n == (cnt_reg == DEPTH))
    else $error("input ready wrong");
  a_almost_full: assert property (
    !$past(i_rst) && $stable(cnt_reg)
    |-> o_almost_full_flag_n == (DEPTH - cnt_reg > af_reg))
    else $error("almost full wrong");
  c_write: cover property (o_word_valid);
  c_full: cover property (!ft_reg && !o_full_or_ready_output_n);
  c_ready: cover property (ft_reg && !o_full_or_ready_output_n);
endmodule
bind fwpfs_top fwpfs_checker #(.DEPTH(DEPTH)) u_chk (.i_sys_clk, .i_rst,
  .i_write_clk_strobe, .i_write_enable_n, .i_input_bus_select_n,
  .i_write_port_async_select, .i_fall_through_mode,
  .i_default_offset_select, .i_scan_or_serial_select, .i_word_drained,
  .i_reg_read, .o_serial_out, .o_full_or_ready_output_n,
  .o_almost_full_flag_n, .o_word_valid, .o_reg_rdata);
`default_nettype wire

// File: fwpfs_upstream.sv
// upstream producer and serial offset host for the write side pins
`timescale 1ns/1ns
`default_nettype none
module fwpfs_upstream (
  // clock
  input wire logic i_sys_clk,
  // write port pins
  output logic o_wclk,
  output logic o_wen_n,
  output logic o_cs_n,
  output logic [35:0] o_data,
  // serial pins
  output logic o_sclk,
  output logic o_sel,
  output logic o_load_n,
  output logic o_rb_n,
  output logic o_si
);
  // idle levels at time zero
  initial begin
    o_wclk = 1'b0;
    o_wen_n = 1'b1;
    o_cs_n = 1'b1;
    o_data = 36'h0;
    o_sclk = 1'b0;
    o_sel = 1'b0;
    o_load_n = 1'b1;
    o_rb_n = 1'b1;
    o_si = 1'b0;
  end
  // one write frame, bus scrambled once held long enough
  task automatic wr(input logic [35:0] d, input logic cs_n, wen_n);
    @(posedge i_sys_clk);
    o_data <= d;
    o_cs_n <= cs_n;
    o_wen_n <= wen_n;
    repeat (4) @(posedge i_sys_clk);
    o_wclk <= 1'b1;
    repeat (4) @(posedge i_sys_clk);
    o_wclk <= 1'b0;
    repeat (4) @(posedge i_sys_clk);
    o_data <= ~d;
    o_cs_n <= 1'b1;
  endtask
  // one shift clock frame, clock idle low outside it
  task automatic ser(input logic sel, load_n, rb_n, si);
    @(posedge i_sys_clk);
    o_sel <= sel;
    o_load_n <= load_n;
    o_rb_n <= rb_n;
    o_si <= si;
    repeat (4) @(posedge i_sys_clk);
    o_sclk <= 1'b1;
    repeat (4) @(posedge i_sys_clk);
    o_sclk <= 1'b0;
    repeat (4) @(posedge i_sys_clk);
    o_si <= ~si;
    o_load_n <= 1'b1;
  endtask
endmodule
`default_nettype wire

// File: tb_fwpfs_top.sv
// self-checking bench for the fifo write port block
`timescale 1ns/1ns
`default_nettype none
`include "fwpfs_params.svh"
module tb_fwpfs_top;
  localparam logic [19:0] PAT = {10'h2B5, 10'h3F0};
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic drn = 1'b0;
  logic asy = 1'b1;
  logic ft = 1'b0;
  logic [1:0] fsel = 2'h0;
  logic [1:0] bw = 2'h0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  wire wclk, wen_n, cs_n, sclk, sel, ld_n, rb_n, si;
  wire so, fr_n, af_n, wv, irq;
  wire [35:0] din, wd;
  wire [31:0] rdata;
  int bad_count = 0;
  int comparisons = 0;
  always #25 clk = ~clk;
  fwpfs_upstream u_up (.i_sys_clk(clk), .o_wclk(wclk), .o_wen_n(wen_n),
    .o_cs_n(cs_n), .o_data(din), .o_sclk(sclk), .o_sel(sel),
    .o_load_n(ld_n), .o_rb_n(rb_n), .o_si(si));
  fwpfs_top #(.DEPTH(16)) u_fwpfs_top (.i_sys_clk(clk), .i_rst(rst),
    .i_write_clk_strobe(wclk), .i_write_enable_n(wen_n),
    .i_input_bus_select_n(cs_n), .i_data(din),
    .i_write_port_async_select(asy), .i_fall_through_mode(ft),
    .i_default_offset_select(fsel), .i_bus_width_select(bw),
    .i_shift_clk(sclk), .i_serial_load_enable_n(ld_n),
    .i_serial_readback_enable_n(rb_n), .i_scan_or_serial_select(sel),
    .i_serial_in(si), .o_serial_out(so), .o_full_or_ready_output_n(fr_n),
    .o_almost_full_flag_n(af_n), .o_word_valid(wv), .o_word_data(wd),
    .i_word_drained(drn), .i_reg_addr(addr), .i_reg_wdata(wdata),
    .i_reg_write(wr), .i_reg_read(rd), .o_reg_rdata(rdata), .o_irq(irq));
  // compare and count
  task automatic chk(input string n, input logic [35:0] s, e);
    comparisons++;
    if (s !== e) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // register port cycles
  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic reg_rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk("rdata", {4'h0, rdata}, {4'h0, e});
  endtask
  task automatic wait_irq(input logic v);
    int i;
    for (i = 0; i < 20 && irq !== v; i++) @(posedge clk);
    chk("irq", {35'h0, irq}, {35'h0, v});
  endtask
  task automatic do_reset(input logic a, f, input logic [1:0] s, b);
    @(posedge clk);
    rst <= 1'b1;
    asy <= a;
    ft <= f;
    fsel <= s;
    bw <= b;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
  // hang guard
  initial begin
    repeat (100000) @(posedge clk);
    bad_count++;
    end_sim();
  end
  // ==========================================================
  // main sequence
  initial begin
    do_reset(1'b1, 1'b0, 2'h0, `FWPFS_BW_36);
    reg_rd(`FWPFS_ADDR_MODE, 32'h0);
    reg_rd(`FWPFS_ADDR_OFFSETS, 32'h0007_0007);
    reg_wr(8'h20, 32'hFFFF_FFFF);
    reg_rd(8'h20, 32'h0);
    reg_rd(`FWPFS_ADDR_MASK, 32'h0);
    u_up.wr(36'h1_1111_1111, 1'b0, 1'b1);
    u_up.wr(36'h2_2222_2222, 1'b1, 1'b0);
    reg_rd(`FWPFS_ADDR_LEVEL, 32'h0);
    u_up.wr(36'h9_ABCD_1234, 1'b0, 1'b0);
    chk("word", wd, 36'h9_ABCD_1234);
    reg_wr(`FWPFS_ADDR_MASK, 32'h4);
    for (int n = 2; n <= 16; n++) begin
      u_up.wr(36'(n), 1'b0, 1'b0);
      chk("af_n", {35'h0, af_n}, 36'(16 - n > 7));
      chk("full_n", {35'h0, fr_n}, 36'(n != 16));
    end
    chk("irq", {35'h0, irq}, 36'h0);
    u_up.wr(36'h5, 1'b0, 1'b0);
    wait_irq(1'b1);
    reg_rd(`FWPFS_ADDR_STATUS, 32'h7);
    wait_irq(1'b0);
    reg_rd(`FWPFS_ADDR_LEVEL, 32'h10);
    @(posedge clk);
    drn <= 1'b1;
    @(posedge clk);
    drn <= 1'b0;
    repeat (4) @(posedge clk);
    chk("full_n", {35'h0, fr_n}, 36'h1);
    $display("standard write session done");
    do_reset(1'b1, 1'b1, 2'h3, `FWPFS_BW_9);
    reg_rd(`FWPFS_ADDR_MODE, 32'h3A);
    reg_rd(`FWPFS_ADDR_OFFSETS, 32'h007F_007F);
    chk("ready_n", {35'h0, fr_n}, 36'h0);
    u_up.wr(36'hF_FFFF_FFFF, 1'b0, 1'b0);
    chk("word", wd, 36'h1FF);
    for (int i = 0; i < 4; i++) u_up.ser(1'b1, 1'b0, 1'b0, 1'b1);
    chk("serial", {35'h0, so}, 36'h0);
    reg_rd(`FWPFS_ADDR_OFFSETS, 32'h007F_007F);
    for (int i = 19; i >= 0; i--) u_up.ser(1'b0, 1'b0, 1'b1, PAT[i]);
    reg_rd(`FWPFS_ADDR_OFFSETS, 32'h03F0_02B5);
    reg_rd(`FWPFS_ADDR_STATUS, 32'hA);
    for (int i = 19; i >= 0; i--) begin
      u_up.ser(1'b0, 1'b1, 1'b0, 1'b0);
      chk("serial", {35'h0, so}, {35'h0, PAT[i]});
    end
    $display("fall-through serial session done");
    do_reset(1'b0, 1'b0, 2'h1, `FWPFS_BW_18);
    reg_rd(`FWPFS_ADDR_MODE, 32'h15);
    reg_rd(`FWPFS_ADDR_OFFSETS, 32'h001F_001F);
    u_up.wr(36'hA_5555_5555, 1'b0, 1'b0);
    chk("word", wd, 36'h0_0001_5555);
    $display("strobe write session done");
    end_sim();
  end
endmodule
`default_nettype wire
